// ### design/flash_host_ctrl.sv
// Host controller that sequences commands onto a byte-wide flash bus.
// Assumes pins are synchronous to SYS_CLK_IN and software owns the port.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter logic [23:0] POLL_LIMIT = 24'hffffff
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CE_IN,
    input  wire logic [1:0]  SW_ADDR_IN,
    input  wire logic [31:0] SW_WDATA_IN,
    input  wire logic        SW_WR_IN,
    input  wire logic        SW_RD_IN,
    output logic      [31:0] SW_RDATA_OUT,
    output logic      [19:0] FLASH_ADDR_OUT,
    input  wire logic [7:0]  FLASH_DQ_IN,
    output logic      [7:0]  FLASH_DQ_OUT,
    output logic             FLASH_DQ_OE_OUT,
    output logic             FLASH_E_N_OUT,
    output logic             FLASH_G_N_OUT,
    output logic             FLASH_W_N_OUT,
    output logic             FLASH_RP_N_OUT
);

    typedef struct packed {
        phase_e      phase;
        op_e         op;
        logic [2:0]  idx;
        logic [7:0]  timer;
        logic [19:0] target;
        logic [7:0]  wdata;
        logic [19:0] pin_addr;
        logic [7:0]  pin_dq;
        pin_ctl_s    pins;
        logic [7:0]  last_rd;
        logic [7:0]  rdata;
        logic        have_prev;
        logic        err_seen;
        logic        busy;
        logic        done;
        logic        err;
        logic [23:0] polls;
        logic [31:0] sw_rdata;
    } state_s;

    state_s s;
    state_s next_s;

    ////////////////////////////////////////////////////////////////////////
    // Number of write cycles each operation places on the bus.
    function automatic logic [2:0] write_count(input op_e op);
        case (op)
            OP_RESET_LONG, OP_AUTOSEL: write_count = 3'd3;
            OP_PROGRAM:                write_count = 3'd4;
            OP_BLOCK_E, OP_CHIP_E:     write_count = 3'd6;
            OP_RESET_ONE, OP_SUSPEND,
            OP_RESUME, OP_QUEUE_BLK:   write_count = 3'd1;
            default:                   write_count = 3'd0;
        endcase
    endfunction

    function automatic logic polls_after(input op_e op);
        polls_after = (op == OP_PROGRAM) || (op == OP_BLOCK_E) ||
                      (op == OP_CHIP_E) || (op == OP_SUSPEND) ||
                      (op == OP_RESUME);
    endfunction

    // Address and data of write cycle idx of an operation.
    function automatic bus_cycle_s write_cycle(input op_e op,
                                               input logic [2:0] idx,
                                               input logic [19:0] target,
                                               input logic [7:0] wdata);
        logic [7:0] code3;
        code3 = CODE_SETUP_E;
        case (op)
            OP_RESET_LONG: code3 = CODE_RESET;
            OP_AUTOSEL:    code3 = CODE_AUTOSEL;
            OP_PROGRAM:    code3 = CODE_PROGRAM;
            default:       code3 = CODE_SETUP_E;
        endcase
        write_cycle = '{UNLOCK_ADDR1, UNLOCK_DATA1};
        if (write_count(op) == 3'd1) begin
            case (op)
                OP_RESET_ONE: write_cycle = '{target, CODE_RESET};
                OP_SUSPEND:   write_cycle = '{target, CODE_SUSPEND};
                OP_QUEUE_BLK: write_cycle = '{target, CODE_BLOCK_E};
                default:      write_cycle = '{target, CODE_RESUME};
            endcase
        end else begin
            case (idx)
                3'd0:    write_cycle = '{UNLOCK_ADDR1, UNLOCK_DATA1};
                3'd1:    write_cycle = '{UNLOCK_ADDR2, UNLOCK_DATA2};
                3'd2:    write_cycle = '{UNLOCK_ADDR1, code3};
                3'd3: begin
                    if (op == OP_PROGRAM) begin
                        write_cycle = '{target, wdata};
                    end else begin
                        write_cycle = '{UNLOCK_ADDR1, UNLOCK_DATA1};
                    end
                end
                3'd4:    write_cycle = '{UNLOCK_ADDR2, UNLOCK_DATA2};
                default: begin
                    if (op == OP_CHIP_E) begin
                        write_cycle = '{UNLOCK_ADDR1, CODE_CHIP_E};
                    end else begin
                        write_cycle = '{target, CODE_BLOCK_E};
                    end
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        bus_cycle_s cyc;
        logic [2:0] nidx;
        cyc = '0;
        nidx = s.idx + 3'd1;
        next_s = s;
        next_s.sw_rdata = '0;
        if (SW_RD_IN) begin
            case (SW_ADDR_IN)
                REG_CTRL:   next_s.sw_rdata = {28'h0000000, s.op};
                REG_ADDR:   next_s.sw_rdata = {12'h000, s.target};
                REG_WDATA:  next_s.sw_rdata = {24'h000000, s.wdata};
                default:    next_s.sw_rdata = {16'h0000, s.rdata, 5'h00,
                                               s.err, s.done, s.busy};
            endcase
        end
        if (SW_WR_IN && !s.busy) begin
            case (SW_ADDR_IN)
                REG_ADDR:  next_s.target = SW_WDATA_IN[19:0];
                REG_WDATA: next_s.wdata = SW_WDATA_IN[7:0];
                default:   next_s.wdata = s.wdata;
            endcase
        end
        case (s.phase)
            P_IDLE: begin
                if (SW_WR_IN && SW_ADDR_IN == REG_CTRL) begin
                    next_s.op = op_e'(SW_WDATA_IN[3:0]);
                    next_s.idx = 3'd0;
                    next_s.busy = 1'b1;
                    next_s.done = 1'b0;
                    next_s.err = 1'b0;
                    next_s.have_prev = 1'b0;
                    next_s.err_seen = 1'b0;
                    next_s.polls = '0;
                    if (next_s.op == OP_HW_RESET) begin
                        next_s.pins.rp_n = 1'b0;
                        next_s.timer = RST_LOW_CYC - 8'd1;
                        next_s.phase = P_RST_LOW;
                    end else if (write_count(next_s.op) == 3'd0) begin
                        next_s.pin_addr = s.target;
                        next_s.pins.e_n = 1'b0;
                        next_s.pins.g_n = 1'b0;
                        next_s.timer = RD_LOW_CYC - 8'd1;
                        next_s.phase = P_RD_LOW;
                    end else begin
                        cyc = write_cycle(next_s.op, 3'd0, s.target, s.wdata);
                        next_s.pin_addr = cyc.addr;
                        next_s.pin_dq = cyc.data;
                        next_s.pins.dq_oe = 1'b1;
                        next_s.pins.e_n = 1'b0;
                        next_s.pins.w_n = 1'b0;
                        next_s.timer = WR_LOW_CYC - 8'd1;
                        next_s.phase = P_WR_LOW;
                    end
                end
            end
            P_WR_LOW: begin
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    // The flash latches data on the rising strobe edge.
                    next_s.pins.w_n = 1'b1;
                    next_s.pins.e_n = 1'b1;
                    next_s.timer = WR_HIGH_CYC - 8'd1;
                    next_s.phase = P_WR_HIGH;
                end
            end
            P_WR_HIGH: begin
                next_s.pins.dq_oe = 1'b0;
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    next_s.idx = nidx;
                    if (nidx < write_count(s.op)) begin
                        cyc = write_cycle(s.op, nidx, s.target, s.wdata);
                        next_s.pin_addr = cyc.addr;
                        next_s.pin_dq = cyc.data;
                        next_s.pins.dq_oe = 1'b1;
                        next_s.pins.e_n = 1'b0;
                        next_s.pins.w_n = 1'b0;
                        next_s.timer = WR_LOW_CYC - 8'd1;
                        next_s.phase = P_WR_LOW;
                    end else if (polls_after(s.op) || s.op == OP_AUTOSEL) begin
                        next_s.pin_addr = s.target;
                        next_s.pins.e_n = 1'b0;
                        next_s.pins.g_n = 1'b0;
                        next_s.timer = RD_LOW_CYC - 8'd1;
                        next_s.phase = P_RD_LOW;
                    end else begin
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.phase = P_IDLE;
                    end
                end
            end
            P_RD_LOW: begin
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    next_s.rdata = FLASH_DQ_IN;
                    next_s.pins.e_n = 1'b1;
                    next_s.pins.g_n = 1'b1;
                    next_s.timer = RD_HIGH_CYC - 8'd1;
                    next_s.phase = P_RD_HIGH;
                end
            end
            P_RD_HIGH: begin
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    next_s.last_rd = s.rdata;
                    next_s.have_prev = 1'b1;
                    next_s.err_seen = s.rdata[ERROR_BIT];
                    next_s.polls = s.polls + 24'd1;
                    if (!polls_after(s.op) || (s.have_prev &&
                        s.last_rd[TOGGLE_BIT] == s.rdata[TOGGLE_BIT])) begin
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.phase = P_IDLE;
                    end else if (s.err_seen || s.polls == POLL_LIMIT) begin
                        // Still toggling after the error bit rose, or the poll limit is reached: failure.
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.err = 1'b1;
                        next_s.phase = P_IDLE;
                    end else begin
                        next_s.pins.e_n = 1'b0;
                        next_s.pins.g_n = 1'b0;
                        next_s.timer = RD_LOW_CYC - 8'd1;
                        next_s.phase = P_RD_LOW;
                    end
                end
            end
            P_RST_LOW: begin
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    next_s.pins.rp_n = 1'b1;
                    next_s.timer = RST_REC_CYC - 8'd1;
                    next_s.phase = P_RST_REC;
                end
            end
            P_RST_REC: begin
                next_s.timer = s.timer - 8'd1;
                if (s.timer == 8'd0) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                    next_s.phase = P_IDLE;
                end
            end
            default: next_s.phase = P_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s <= '{phase: P_IDLE, op: OP_READ_ARRAY,
                   pins: '{e_n: 1'b1, g_n: 1'b1, w_n: 1'b1,
                           rp_n: 1'b1, dq_oe: 1'b0},
                   default: '0};
        end else if (CE_IN) begin
            s <= next_s;
        end
    end

    assign SW_RDATA_OUT = s.sw_rdata;
    assign FLASH_ADDR_OUT = s.pin_addr;
    assign FLASH_DQ_OUT = s.pin_dq;
    assign FLASH_DQ_OE_OUT = s.pins.dq_oe;
    assign FLASH_E_N_OUT = s.pins.e_n;
    assign FLASH_G_N_OUT = s.pins.g_n;
    assign FLASH_W_N_OUT = s.pins.w_n;
    assign FLASH_RP_N_OUT = s.pins.rp_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks are disabled while the clock enable holds state frozen.
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN || !CE_IN);

    sequence write_strobe_s;
        $fell(s.pins.w_n);
    endsequence
    sequence pulse_held_s;
        (!s.pins.w_n && s.pins.dq_oe) [*7] ##1 s.pins.w_n;
    endsequence

    no_bus_fight_a: assert property (!(!s.pins.w_n && !s.pins.g_n))
        else $error("Write and output strobes low together.");
    write_pulse_a: assert property (write_strobe_s |-> pulse_held_s)
        else $error("Write strobe pulse has the wrong length.");
    unlock_one_a: assert property (write_strobe_s and s.idx == 3'd0 &&
        write_count(s.op) > 3'd1 |-> s.pin_addr[10:0] == 11'h555 &&
        s.pin_dq == UNLOCK_DATA1)
        else $error("First unlock cycle is wrong.");
    unlock_two_a: assert property (write_strobe_s and s.idx == 3'd1 |->
        s.pin_addr[10:0] == 11'h2aa && s.pin_dq == UNLOCK_DATA2)
        else $error("Second unlock cycle is wrong.");
    erase_relock_a: assert property (write_strobe_s and s.idx == 3'd3 &&
        s.op != OP_PROGRAM |-> s.pin_dq == UNLOCK_DATA1)
        else $error("Erase misses the repeated unlock.");
    program_data_a: assert property (write_strobe_s and s.idx == 3'd3 &&
        s.op == OP_PROGRAM |-> s.pin_addr == s.target &&
        s.pin_dq == s.wdata)
        else $error("Program address or data is wrong.");
    chip_confirm_a: assert property (write_strobe_s and s.idx == 3'd5 &&
        s.op == OP_CHIP_E |-> s.pin_dq == CODE_CHIP_E)
        else $error("Chip erase confirm is wrong.");
    block_confirm_a: assert property (write_strobe_s and s.idx == 3'd5 &&
        s.op == OP_BLOCK_E |-> s.pin_dq == CODE_BLOCK_E &&
        s.pin_addr == s.target)
        else $error("Block erase confirm is wrong.");
    suspend_code_a: assert property (write_strobe_s and
        s.op == OP_SUSPEND |-> s.pin_dq == CODE_SUSPEND)
        else $error("Suspend code is wrong.");
    poll_address_a: assert property ($fell(s.pins.g_n) &&
        polls_after(s.op) |-> s.pin_addr == s.target)
        else $error("Status poll at the wrong address.");
    toggle_done_a: assert property (s.phase == P_RD_HIGH &&
        s.timer == 8'd0 && polls_after(s.op) && s.have_prev &&
        s.last_rd[TOGGLE_BIT] == s.rdata[TOGGLE_BIT] |=>
        !s.busy && s.done && !s.err)
        else $error("Equal toggle reads did not end the poll.");

endmodule
`default_nettype wire

// ### design/flash_host_pkg.sv
// Constants, types and timing for the parallel-flash command host.
// Assumes a 200 MHz system clock and a byte-wide flash on plain pins.
package flash_host_pkg;

    localparam int          CLK_NS       = 5;
    localparam int          WR_LOW_NS    = 35;
    localparam int          WR_HIGH_NS   = 30;
    localparam int          RD_LOW_NS    = 80;
    localparam int          RD_HIGH_NS   = 30;
    localparam int          RST_LOW_NS   = 500;
    localparam int          RST_REC_NS   = 50;
    localparam logic [7:0]  WR_LOW_CYC   = 8'((WR_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  WR_HIGH_CYC  = 8'((WR_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  RD_LOW_CYC   = 8'((RD_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  RD_HIGH_CYC  = 8'((RD_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  RST_LOW_CYC  = 8'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  RST_REC_CYC  = 8'((RST_REC_NS + CLK_NS - 1) / CLK_NS);

    localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
    localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CODE_RESET   = 8'hf0;
    localparam logic [7:0]  CODE_AUTOSEL = 8'h90;
    localparam logic [7:0]  CODE_PROGRAM = 8'ha0;
    localparam logic [7:0]  CODE_SETUP_E = 8'h80;
    localparam logic [7:0]  CODE_BLOCK_E = 8'h30;
    localparam logic [7:0]  CODE_CHIP_E  = 8'h10;
    localparam logic [7:0]  CODE_SUSPEND = 8'hb0;
    localparam logic [7:0]  CODE_RESUME  = 8'h30;

    localparam int          TOGGLE_BIT   = 6;
    localparam int          ERROR_BIT    = 5;
    localparam logic [7:0]  STATUS_MASK  = 8'hec;

    localparam logic [1:0]  REG_CTRL     = 2'h0;
    localparam logic [1:0]  REG_ADDR     = 2'h1;
    localparam logic [1:0]  REG_WDATA    = 2'h2;
    localparam logic [1:0]  REG_STATUS   = 2'h3;
    localparam int          ST_BUSY      = 0;
    localparam int          ST_DONE      = 1;
    localparam int          ST_ERR       = 2;
    localparam int          ST_DATA_LSB  = 8;

    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_RESET_LONG = 4'h1,
        OP_RESET_ONE  = 4'h2,
        OP_AUTOSEL    = 4'h3,
        OP_PROGRAM    = 4'h4,
        OP_BLOCK_E    = 4'h5,
        OP_CHIP_E     = 4'h6,
        OP_SUSPEND    = 4'h7,
        OP_RESUME     = 4'h8,
        OP_QUEUE_BLK  = 4'h9,
        OP_HW_RESET   = 4'ha
    } op_e;

    typedef enum logic [2:0] {
        P_IDLE    = 3'h0,
        P_WR_LOW  = 3'h1,
        P_WR_HIGH = 3'h2,
        P_RD_LOW  = 3'h3,
        P_RD_HIGH = 3'h4,
        P_RST_LOW = 3'h5,
        P_RST_REC = 3'h6
    } phase_e;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  data;
    } bus_cycle_s;

    typedef struct packed {
        logic       e_n;
        logic       g_n;
        logic       w_n;
        logic       rp_n;
        logic       dq_oe;
    } pin_ctl_s;

endpackage

// ### verif/flash_dev_model.sv
// Behavioural model of the byte-wide flash behind the command host.
// Assumes the host never lowers write and output enable together.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MFR_CODE = 8'h5e, // Arbitrary value.
    parameter logic [2:0] PROT_BLK = 3'h1
) (
    input  wire logic [19:0] addr_in,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    input  wire logic        e_n_in,
    input  wire logic        g_n_in,
    input  wire logic        w_n_in,
    input  wire logic        rp_n_in,
    input  wire logic        fail_in
);
////////////////////////////////////////////////////////////
    // One byte a block keeps the model small; offsets alias.
    logic [7:0] mem [8];
    logic [7:0] rd_q = 8'h00;
    logic [7:0] pdat = 8'h00;
    logic [2:0] step = 3'h0;
    logic [2:0] mode = 3'h0;
    logic       tog  = 1'b0;
    logic       fail = 1'b0;
    int         left = 0;
    logic       wr_n;
    logic       rd_n;
    logic       a5;
    logic       a2;
    logic [2:0] blk;
    // Strobes are merged so that skew between enables cannot race.
    assign wr_n   = e_n_in | w_n_in;
    assign rd_n   = e_n_in | g_n_in;
    assign a5     = addr_in[10:0] == 11'h555;
    assign a2     = addr_in[10:0] == 11'h2aa;
    assign blk    = addr_in[15:13];
    // A released bus shows the inverse of the last byte.
    assign dq_out = rd_n ? ~rd_q : rd_q;
    initial foreach (mem[i]) mem[i] = 8'hff;
    always @(posedge wr_n or negedge rd_n or negedge rp_n_in) begin
        if (!rp_n_in) begin
            mode = 3'h0;
            step = 3'h0;
        end else if (!rd_n) begin
            case (mode)
                3'h1: rd_q = addr_in[1:0] == 2'b10 ? {7'h0, blk == PROT_BLK}
                                                 : MFR_CODE;
                3'h2: rd_q = {~pdat[7], tog, fail, 2'b00, 1'b1, tog, ~tog};
                3'h3: rd_q = {1'b0, tog, 1'b0, 2'b11, tog, 2'b10};
                3'h4: rd_q = {2'b11, 1'b0, tog, 1'b1, tog, 2'b01};
                default: rd_q = mem[blk];
            endcase
            tog = ~tog;
            if (mode inside {3'h2, 3'h3} && !fail) begin
                left = left - 1;
                if (left == 0) mode = 3'h0;
            end
        end else if (^{dq_in, addr_in} !== 1'bx) begin
            if (mode == 3'h3) begin
                if (dq_in == 8'hb0) mode = 3'h4;
            end else if (mode == 3'h4 && dq_in == 8'h30) begin
                mode = 3'h3;
            end else if (dq_in == 8'hf0) begin
                mode = 3'h0;
                step = 3'h0;
                fail = 1'b0;
            end else begin
                if (step == 3'h0) mode = 3'h0;
                case (step)
                    3'h0, 3'h4: step = (a5 && dq_in == 8'haa) ? step + 3'h1
                                                             : 3'h0;
                    3'h1, 3'h5: step = (a2 && dq_in == 8'h55) ? step + 3'h1
                                                             : 3'h0;
                    3'h2: begin
                        step = dq_in == 8'ha0 ? 3'h3 : 3'h0;
                        if (dq_in == 8'h80) step = 3'h4;
                        if (dq_in == 8'h90) mode = 3'h1;
                    end
                    3'h3: begin
                        pdat = dq_in;
                        mem[blk] = mem[blk] & dq_in;
                        fail = fail_in;
                        mode = 3'h2;
                        left = 4;
                        step = 3'h0;
                    end
                    default: begin
                        step = 3'h0;
                        if (dq_in == 8'h30 || (dq_in == 8'h10 && a5)) begin
                            mode = 3'h3;
                            left = dq_in == 8'h30 ? 6 : 12;
                            foreach (mem[i])
                                if ((dq_in == 8'h10 || i == blk)
                                    && i != PROT_BLK) mem[i] = 8'hff;
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/test_flash_host_ctrl.sv
// Self-checking bench: the command host drives the flash model.
// Assumes the model counts busy reads and shows status meanwhile.
`timescale 1ns/1ps
`default_nettype none
module test_flash_host_ctrl;
    import flash_host_pkg::*;
    typedef struct packed {
        logic [3:0]  c;
        logic [19:0] a;
        logic [7:0]  d;
        logic        f;
        logic [7:0]  m;
        logic [7:0]  x;
        logic        e;
    } step_s;
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic [1:0]  sw_addr  = 2'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr    = 1'b0;
    logic        sw_rd    = 1'b0;
    logic        fail     = 1'b0;
    logic [31:0] sw_rdata;
    logic [31:0] s;
    logic [19:0] f_addr;
    logic [7:0]  dq_host;
    logic [7:0]  dq_dev;
    logic [7:0]  dq_bus;
    logic        dq_oe;
    logic        e_n;
    logic        g_n;
    logic        w_n;
    logic        rp_n;
    int          error_cnt = 0;
    int          checked   = 0;
    // The chip erase outlasts the short poll limit, so suspend can follow.
    step_s       tbl [14] = '{
        '{OP_AUTOSEL, 20'h02002, 8'h00, 1'b0, 8'hff, 8'h01, 1'b0},
        '{OP_AUTOSEL, 20'h04002, 8'h00, 1'b0, 8'hff, 8'h00, 1'b0},
        '{OP_HW_RESET, 20'h0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0},
        '{OP_PROGRAM, 20'h04000, 8'h5a, 1'b0, 8'hff, 8'h5a, 1'b0},
        '{OP_READ_ARRAY, 20'h04000, 8'h00, 1'b0, 8'hff, 8'h5a, 1'b0},
        '{OP_BLOCK_E, 20'h04000, 8'h00, 1'b0, 8'hff, 8'hff, 1'b0},
        '{OP_PROGRAM, 20'h06000, 8'h3c, 1'b1, 8'h00, 8'h00, 1'b1},
        '{OP_RESET_ONE, 20'h06000, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0},
        '{OP_RESET_LONG, 20'h0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0},
        '{OP_QUEUE_BLK, 20'h06000, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0},
        '{OP_CHIP_E, 20'h06000, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1},
        '{OP_SUSPEND, 20'h06000, 8'h00, 1'b0, 8'he8, 8'hc8, 1'b0},
        '{OP_READ_ARRAY, 20'h06000, 8'h00, 1'b0, 8'he8, 8'hc8, 1'b0},
        '{OP_RESUME, 20'h06000, 8'h00, 1'b0, 8'hff, 8'hff, 1'b0}};
    assign dq_bus = dq_oe ? dq_host : dq_dev;
    always #2.5 clk = ~clk;
    flash_host_ctrl #(.POLL_LIMIT(24'h000008)) flash_host_ctrl_inst (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
        .SW_ADDR_IN(sw_addr), .SW_WDATA_IN(sw_wdata), .SW_WR_IN(sw_wr),
        .SW_RD_IN(sw_rd), .SW_RDATA_OUT(sw_rdata), .FLASH_ADDR_OUT(f_addr),
        .FLASH_DQ_IN(dq_bus), .FLASH_DQ_OUT(dq_host),
        .FLASH_DQ_OE_OUT(dq_oe), .FLASH_E_N_OUT(e_n), .FLASH_G_N_OUT(g_n),
        .FLASH_W_N_OUT(w_n), .FLASH_RP_N_OUT(rp_n));
    flash_dev_model flash_dev_model_inst (
        .addr_in(f_addr), .dq_in(dq_bus), .dq_out(dq_dev), .e_n_in(e_n),
        .g_n_in(g_n), .w_n_in(w_n), .rp_n_in(rp_n), .fail_in(fail));
////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A gap cycle after each write keeps one assignment per time step.
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [1:0] a, output logic [31:0] d);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd   <= 1'b0;
        @(negedge clk);
        d = sw_rdata;
        @(posedge clk);
    endtask
    task automatic op(input logic [3:0] c, input logic [19:0] a,
                      input logic [7:0] d);
        wr(REG_ADDR, {12'h0, a});
        wr(REG_WDATA, {24'h0, d});
        wr(REG_CTRL, {28'h0, c});
        for (int i = 0; i < 400; i++) begin
            rd(REG_STATUS, s);
            if (s[ST_BUSY] === 1'b0) break;
        end
        if (s[ST_BUSY] !== 1'b0) begin
            error_cnt++;
            close_out();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("pins", {27'h0, e_n, g_n, w_n, rp_n, dq_oe}, 32'h1e);
        rd(REG_STATUS, s);
        chk("idle", s, 32'h0);
        @(negedge clk);
        chk("stands", sw_rdata, 32'h0);
        @(posedge clk);
        for (int k = 0; k < 14; k++) begin
            fail <= tbl[k].f;
            op(tbl[k].c, tbl[k].a, tbl[k].d);
            chk("byte", {24'h0, s[15:8] & tbl[k].m}, {24'h0, tbl[k].x});
            chk("err", {31'h0, s[2]}, {31'h0, tbl[k].e});
            if (!tbl[k].e) chk("done", {31'h0, s[1]}, 32'h1);
            rd(REG_CTRL, s);
            chk("ctrl", s, {28'h0, tbl[k].c});
            rd(REG_ADDR, s);
            chk("addr", s, {12'h0, tbl[k].a});
        end
        close_out();
    end
endmodule
`default_nettype wire
